// *** src/lsd_top.sv ***
/*
  Segment panel timing and waveform controller with double-buffered pixels.
  Assumes config, write and request ports come from logic on clk;
  source clocks come from pins and are synchronised in the source stage.
*/
`timescale 1ns/1ps
module lsd_top #(
	parameter int BLINK_HALF_CYC = lsd_pkg::BLINK_4HZ_HALF_CYC
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    srst,
	// Source clock pins
	input  wire logic                    ext_xtal_clk,
	input  wire logic                    int_rc_clk_8m,
	// Software setup and pixel writes
	input  wire lsd_pkg::lsd_cfg_s       cfg,
	input  wire lsd_pkg::lsd_wr_s        wr,
	input  wire logic                    upd_req,
	input  wire logic                    upd_done_clr,
	// Status
	output logic                         update_done,
	output logic                         frame_mark,
	output logic                         running,
	// Panel level codes
	output logic [7:0][2:0]              bp_level,
	output logic [31:0][2:0]             fp_level
);
	lsd_pkg::lsd_state_s  q;          // Registered state
	lsd_pkg::lsd_state_s  d;          // Next state
	logic                 tick;       // Divided source tick
	logic                 fb;         // Frame boundary this cycle
	logic                 pol;        // Current drive polarity
	logic [24:0]          blink_lim;  // Blink half period minus one
	logic                 run_q;
	// Local names for the state codes
	localparam lsd_pkg::lsd_state_e ST_IDLE  = lsd_pkg::ST_IDLE;
	localparam lsd_pkg::lsd_state_e ST_DRIVE = lsd_pkg::ST_DRIVE;
	localparam lsd_pkg::lsd_state_e ST_DEAD  = lsd_pkg::ST_DEAD;

	// Phases per frame for a duty code
	function automatic logic [3:0] nph(input logic [2:0] duty);
		unique case (duty)
			lsd_pkg::DUTY_STATIC: nph = 4'h1;
			lsd_pkg::DUTY_1_2:    nph = 4'h2;
			lsd_pkg::DUTY_1_3:    nph = 4'h3;
			lsd_pkg::DUTY_1_4:    nph = 4'h4;
			default:              nph = 4'h8;
		endcase
	endfunction

	// Level code for a line role, mirrored by polarity
	function automatic logic [2:0] lvl(input logic [1:0] role, input logic p, input logic [1:0] bias);
		logic [2:0] vm;
		vm = {1'b0, bias} + 3'h1;
		unique case (role)
			lsd_pkg::ROLE_BP_SEL:   lvl = p ? vm : 3'h0;
			lsd_pkg::ROLE_BP_UNSEL: lvl = p ? 3'h1 : vm - 3'h1;
			lsd_pkg::ROLE_FP_ON:    lvl = p ? 3'h0 : vm;
			lsd_pkg::ROLE_FP_OFF: begin
				if (bias == lsd_pkg::BIAS_1_4) begin
					lvl = 3'h2;
				end else if (bias == lsd_pkg::BIAS_1_3) begin
					lvl = p ? 3'h2 : 3'h1;
				end else if (bias == lsd_pkg::BIAS_1_2) begin
					lvl = 3'h1;
				end else begin
					lvl = p ? vm : 3'h0;
				end
			end
		endcase
	endfunction

	// Whether a pixel belongs to the blink group
	function automatic logic blinked(input logic [2:0] mode, input logic [2:0] ph, input logic fp0);
		logic [3:0] n;
		n = (mode == lsd_pkg::BLINK_8) ? 4'h8 : {1'b0, mode};
		blinked = (mode == lsd_pkg::BLINK_ALL) ||
			(fp0 && mode != lsd_pkg::BLINK_OFF && {1'b0, ph} < n);
	endfunction

	// Divided source clock
	lsd_clk_src u_src (
		.clk           (clk),
		.srst          (srst),
		.ext_xtal_clk  (ext_xtal_clk),
		.int_rc_clk_8m (int_rc_clk_8m),
		.src_sel       (cfg.src_sel),
		.tick          (tick)
	);

	// Normal mode flips inside each phase, inversion mode per frame
	assign pol = q.cfg.invert ? q.fpol : q.half;
	assign blink_lim = 25'(BLINK_HALF_CYC << (lsd_pkg::RATE_4HZ - cfg.blink_rate)) - 25'h1;

	// Next-state logic
	always_comb begin
		d = q;
		fb = 1'b0;
		d.frame_mark = 1'b0;
		// Software side of the pixel memory
		if (wr.en) begin
			d.shadow[wr.row] = wr.data;
		end
		if (upd_req) begin
			d.upd_pend = 1'b1;
		end
		if (upd_done_clr) begin
			d.upd_done = 1'b0;
		end
		// Blink timebase, free running
		if (q.blink_cnt >= blink_lim) begin
			d.blink_cnt = '0;
			d.blink_on = ~q.blink_on;
		end else begin
			d.blink_cnt = q.blink_cnt + 25'h1;
		end
		// Phase sequencer
		unique case (q.state)
			ST_IDLE: begin
				fb = cfg.en;
			end
			ST_DRIVE: if (tick) begin
				if (q.pre != q.cfg.phase_len) begin
					d.pre = q.pre + 16'h1;
				end else begin
					d.pre = '0;
					d.half = ~q.half;
					if (q.half) begin
						// Last phase of the frame
						if ({1'b0, q.phase} == nph(q.cfg.duty) - 4'h1) begin
							if (q.cfg.dead != 3'h0) begin
								d.state = ST_DEAD;
								d.dead = 3'h0;
							end else begin
								fb = 1'b1;
							end
						end else begin
							d.phase = q.phase + 3'h1;
						end
					end
				end
			end
			ST_DEAD: if (tick) begin
				if (q.pre != q.cfg.phase_len) begin
					d.pre = q.pre + 16'h1;
				end else begin
					d.pre = '0;
					d.half = ~q.half;
					if (q.half) begin
						// Dead periods last whole phases
						if (q.dead == q.cfg.dead - 3'h1) begin
							fb = 1'b1;
						end else begin
							d.dead = q.dead + 3'h1;
						end
					end
				end
			end
		endcase
		// Frame boundary: new setup, swap, polarity
		if (fb) begin
			d.state = cfg.en ? ST_DRIVE : ST_IDLE;
			d.cfg = cfg;
			d.phase = 3'h0;
			d.half = 1'b0;
			d.pre = '0;
			d.fpol = ~q.fpol;
			// Inverted frame pairs share one blink state, else blinking leaves DC
			if (!cfg.invert || q.fpol) begin
				d.blink_frame = q.blink_on;
			end
			d.frame_mark = 1'b1;
			if (q.upd_pend) begin
				d.active = q.shadow;
				d.upd_pend = upd_req;
				d.upd_done = 1'b1;
			end
		end
		// Line levels from current state
		for (int b = 0; b < lsd_pkg::NUM_BP; b++) begin
			if (q.state == ST_DRIVE && b < int'(nph(q.cfg.duty))) begin
				d.bp_lvl[b] = lvl((b == int'(q.phase)) ? lsd_pkg::ROLE_BP_SEL : lsd_pkg::ROLE_BP_UNSEL,
					pol, q.cfg.bias);
			end else begin
				d.bp_lvl[b] = 3'h0;
			end
		end
		for (int f = 0; f < lsd_pkg::NUM_FP; f++) begin
			if (q.state == ST_DRIVE) begin
				d.fp_lvl[f] = lvl((q.active[q.phase][f] &&
					!(q.blink_frame && blinked(q.cfg.blink_mode, q.phase, f == 0))) ?
					lsd_pkg::ROLE_FP_ON : lsd_pkg::ROLE_FP_OFF, pol, q.cfg.bias);
			end else begin
				d.fp_lvl[f] = 3'h0;
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
			q.state <= ST_IDLE;
			run_q <= 1'b0;
		end else begin
			q <= d;
			run_q <= (d.state != ST_IDLE);
		end
	end

	// Outputs straight from flops
	assign update_done = q.upd_done;
	assign frame_mark = q.frame_mark;
	assign running = run_q;
	assign bp_level = q.bp_lvl;
	assign fp_level = q.fp_lvl;

	a_bp_unused: assert property (@(posedge clk) disable iff (srst)
		(q.state == ST_DRIVE && q.cfg.duty == lsd_pkg::DUTY_1_4) |=> bp_level[7] == 3'h0)
		else $error("unused backplane driven");
	a_bp_select: assert property (@(posedge clk) disable iff (srst)
		(q.state == ST_DRIVE && $stable(q.state)) |=>
			bp_level[$past(q.phase)] == $past(lvl(lsd_pkg::ROLE_BP_SEL, pol, q.cfg.bias)))
		else $error("selected backplane level wrong");
	a_phase_bound: assert property (@(posedge clk) disable iff (srst)
		q.state == ST_DRIVE |-> {1'b0, q.phase} < nph(q.cfg.duty))
		else $error("phase beyond duty");
	a_level_cap: assert property (@(posedge clk) disable iff (srst)
		q.state == ST_DRIVE |=> bp_level[0] <= {1'b0, $past(q.cfg.bias)} + 3'h1)
		else $error("level above bias range");
	a_pre_bound: assert property (@(posedge clk) disable iff (srst)
		q.state != ST_IDLE |-> q.pre <= q.cfg.phase_len)
		else $error("prescaler overran");
	a_swap_edge: assert property (@(posedge clk) disable iff (srst)
		$changed(q.active) |-> q.frame_mark)
		else $error("active buffer changed mid frame");
	a_dead_zero: assert property (@(posedge clk) disable iff (srst)
		q.state == ST_DEAD |=> (fp_level == '0 && bp_level == '0))
		else $error("dead time not blank");
	a_inv_steady: assert property (@(posedge clk) disable iff (srst)
		(q.state == ST_DRIVE && q.cfg.invert && !q.frame_mark && $past(q.state) == ST_DRIVE) |-> $stable(pol))
		else $error("inversion polarity moved in frame");
	a_blink_blank: assert property (@(posedge clk) disable iff (srst)
		(q.state == ST_DRIVE && q.blink_frame && q.cfg.blink_mode == lsd_pkg::BLINK_ALL) |=>
			fp_level[0] == $past(lvl(lsd_pkg::ROLE_FP_OFF, pol, q.cfg.bias)))
		else $error("blinking pixel not blanked");
	a_done_cause: assert property (@(posedge clk) disable iff (srst)
		$rose(q.upd_done) |-> (q.frame_mark && $past(q.upd_pend)))
		else $error("update flagged without swap");
	a_done_sticky: assert property (@(posedge clk) disable iff (srst)
		(q.upd_done && !upd_done_clr) |=> q.upd_done)
		else $error("update flag lost");
endmodule

// *** src/lsd_pkg.sv ***
/*
  Shared constants and carrier types of the segment panel timing controller.
  Assumes a single 25 MHz clock with synchronous active-high reset.
*/
// How it works
// - Drives 8 backplane and 32 frontplane lines
// - Backplanes in the duty and all frontplanes swing symmetric, zero average voltage
// - Duty static, 1/2, 1/3, 1/4 or 1/8
// - Bias static, 1/2, 1/3 or 1/4 levels
// - Software sets phase length, hence frame rate
// - Pixel memory double buffered against tearing
// - Timing from crystal/16 or 8 MHz RC/8
// - Zero to 7 dead phases between frames
// - Optional frame-wise phase inversion mode
// - Blink 1, 2, 3, 4, 8 or all pixels
// - Blink rate 0.5, 1, 2 or 4 Hz
package lsd_pkg;
	localparam int NUM_BP = 8;                       // Backplane lines
	localparam int NUM_FP = 32;                      // Frontplane lines
	localparam int LVL_W  = 3;                       // Drive level code width
	// Source dividers, terminal counts
	localparam logic [3:0] XTAL_DIV_LAST = 4'hF;     // Crystal divided by 16
	localparam logic [3:0] RC_DIV_LAST   = 4'h7;     // RC divided by 8
	// Duty codes
	localparam logic [2:0] DUTY_STATIC = 3'h0;
	localparam logic [2:0] DUTY_1_2    = 3'h1;
	localparam logic [2:0] DUTY_1_3    = 3'h2;
	localparam logic [2:0] DUTY_1_4    = 3'h3;
	localparam logic [2:0] DUTY_1_8    = 3'h4;
	// Bias codes, top level is code plus one
	localparam logic [1:0] BIAS_STATIC = 2'h0;
	localparam logic [1:0] BIAS_1_2    = 2'h1;
	localparam logic [1:0] BIAS_1_3    = 2'h2;
	localparam logic [1:0] BIAS_1_4    = 2'h3;
	// Blink selections
	localparam logic [2:0] BLINK_OFF = 3'h0;
	localparam logic [2:0] BLINK_8   = 3'h5;
	localparam logic [2:0] BLINK_ALL = 3'h6;
	// Blink rate codes: 0 is 0.5 Hz up to 3 is 4 Hz
	localparam logic [1:0] RATE_4HZ = 2'h3;
	// Drive roles
	localparam logic [1:0] ROLE_BP_SEL   = 2'h0;
	localparam logic [1:0] ROLE_BP_UNSEL = 2'h1;
	localparam logic [1:0] ROLE_FP_ON    = 2'h2;
	localparam logic [1:0] ROLE_FP_OFF   = 2'h3;
	// Timing
	localparam int CLK_PERIOD_NS      = 40;
	localparam int BLINK_4HZ_HALF_NS  = 125_000_000;
	localparam int BLINK_4HZ_HALF_CYC = BLINK_4HZ_HALF_NS / CLK_PERIOD_NS;
	localparam int BLINK_W            = 25;

	// Configuration carried from software
	typedef struct packed {
		logic        en;          // Run display
		logic        src_sel;     // 0 crystal, 1 RC
		logic [2:0]  duty;
		logic [1:0]  bias;
		logic        invert;      // Frame-wise inversion
		logic [2:0]  dead;        // Dead phases per frame
		logic [15:0] phase_len;   // Source ticks per half phase, minus one
		logic [2:0]  blink_mode;
		logic [1:0]  blink_rate;
	} lsd_cfg_s;

	// Pixel write port, one backplane row per write
	typedef struct packed {
		logic        en;
		logic [2:0]  row;
		logic [31:0] data;
	} lsd_wr_s;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_DRIVE = 3'b010,
		ST_DEAD  = 3'b100
	} lsd_state_e;

	// Controller state
	typedef struct packed {
		lsd_state_e                  state;
		lsd_cfg_s                    cfg;          // Frame-latched setup
		logic [15:0]                 pre;          // Half-phase prescaler
		logic                        half;
		logic [2:0]                  phase;
		logic [2:0]                  dead;
		logic                        fpol;         // Frame polarity
		logic [7:0][31:0]            shadow;       // Software side
		logic [7:0][31:0]            active;       // Displayed side
		logic                        upd_pend;
		logic                        upd_done;
		logic [BLINK_W-1:0]          blink_cnt;
		logic                        blink_on;
		logic                        blink_frame;  // Blink phase of frame
		logic                        frame_mark;
		logic [7:0][LVL_W-1:0]       bp_lvl;
		logic [31:0][LVL_W-1:0]      fp_lvl;
	} lsd_state_s;

	// Clock source stage state
	typedef struct packed {
		logic [2:0] xs;    // Crystal sync chain plus edge stage
		logic [2:0] rs;    // RC sync chain plus edge stage
		logic [3:0] div;
		logic       tick;
	} lsd_src_s;
endpackage

// *** src/lsd_clk_src.sv ***
/*
  Source clock selection and division into single-cycle ticks.
  Assumes both source clocks are well below half of clk.
*/
`timescale 1ns/1ps
module lsd_clk_src (
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Source pins
	input  wire logic ext_xtal_clk,
	input  wire logic int_rc_clk_8m,
	input  wire logic src_sel,
	// Tick out
	output logic      tick
);
	lsd_pkg::lsd_src_s q;  // Registered state
	lsd_pkg::lsd_src_s d;  // Next state
	logic              edge_seen;
	logic [3:0]        last;

	// Sync, edge detect on second stage only, divide
	always_comb begin
		d = q;
		d.xs = {q.xs[1:0], ext_xtal_clk};
		d.rs = {q.rs[1:0], int_rc_clk_8m};
		d.tick = 1'b0;
		edge_seen = src_sel ? (q.rs[1] & ~q.rs[2]) : (q.xs[1] & ~q.xs[2]);
		last = src_sel ? lsd_pkg::RC_DIV_LAST : lsd_pkg::XTAL_DIV_LAST;
		if (edge_seen) begin
			// Terminal count gives one tick
			if (q.div >= last) begin
				d.div = 4'h0;
				d.tick = 1'b1;
			end else begin
				d.div = q.div + 4'h1;
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;

	// Ticks are spaced by more than eight clk cycles
	a_tick_spacing: assert property (@(posedge clk) disable iff (srst)
		q.tick |=> !q.tick [*8])
		else $error("source ticks too close");
endmodule

// *** verif/lsd_panel_model.sv ***
/*
  Panel glass model: integrates the drive seen by every pixel.
  Assumes level codes settle on clk and frame_mark ends each frame.
*/
`timescale 1ns/1ps
module lsd_panel_model (
	// Clock and frame
	input  wire logic             clk,
	input  wire logic             frame_mark,
	// Drive levels
	input  wire logic [7:0][2:0]  bp_level,
	input  wire logic [31:0][2:0] fp_level,
	// Check control
	input  wire logic             chk,
	input  wire logic             inv,
	input  var  int               n_bp,
	// Results
	output int                    dc_errs,
	output int                    dc_chks
);
	int   acc [8][32];       // Running net drive per pixel
	int   s1  [8][32];       // Sum at the last boundary
	int   s2  [8][32];       // Sum one boundary earlier
	logic mark_q    = 1'b0;  // Boundary seen at the last edge
	logic pos_frame = 1'b0;  // Frame drove positive polarity

	// Integrate, compare a frame (or an inverted pair) at its end
	always @(posedge clk) begin
		// First level of a frame: selected backplane 0 shows its polarity
		if (mark_q)
			pos_frame = bp_level[0] != 3'h0;
		foreach (acc[b, f]) begin
			acc[b][f] += int'(bp_level[b]) - int'(fp_level[f]);
			if (frame_mark === 1'b1) begin
				// Inverted pairs close on the positive frame
				if (chk && b < n_bp && (!inv || pos_frame)) begin
					dc_chks++;
					if (acc[b][f] != (inv ? s2[b][f] : s1[b][f])) begin
						dc_errs++;
						$display("[FAIL] %0t net drive %h vs %h", $time, acc[b][f], inv ? s2[b][f] : s1[b][f]);
					end
				end
				s2[b][f] = s1[b][f];
				s1[b][f] = acc[b][f];
			end
		end
		mark_q = frame_mark === 1'b1;
	end
endmodule

// *** verif/tb.sv ***
/*
  Bench for the segment panel controller: predicts every half-phase level and frame length.
  Assumes the crystal pin runs at clk/4 so ticks are exact, and the panel model watches the levels.
*/
`timescale 1ns/1ps
module tb;
	logic              clk, srst, rc, upd_req, clr, done, fmark, run, chk, inv, ball, pf;
	logic [1:0]        xdiv;          // Crystal pin divider
	lsd_pkg::lsd_cfg_s cfg;
	lsd_pkg::lsd_wr_s  wr;
	logic [7:0][2:0]   bpl, eb;       // Backplane levels, expected
	logic [31:0][2:0]  fpl, ef;       // Frontplane levels, expected
	logic [31:0]       mem [8];       // Rows now displayed
	int                n_bp, dc_errs, dc_chks, num_errors, check_count, seed, blanked;
	int                top, bias, dead, hl, ng, sel;
	// Setups: duty, bias, invert, dead, phase_len, blink mode, blink rate, source
	int tbl [8][8] = '{'{0,0,0,0,0,0,0,0}, '{1,1,0,1,0,1,1,0}, '{2,2,1,2,1,2,2,0}, '{3,2,0,7,0,3,3,0},
		'{4,3,0,0,0,6,0,0}, '{3,3,1,0,0,4,1,0}, '{4,3,1,3,0,5,2,0}, '{1,1,0,0,0,0,0,1}};

	lsd_top #(.BLINK_HALF_CYC(20)) dut_u (.clk(clk), .srst(srst), .ext_xtal_clk(xdiv[1]), .int_rc_clk_8m(rc),
		.cfg(cfg), .wr(wr), .upd_req(upd_req), .upd_done_clr(clr), .update_done(done), .frame_mark(fmark),
		.running(run), .bp_level(bpl), .fp_level(fpl));
	lsd_panel_model panel_u (.clk(clk), .frame_mark(fmark), .bp_level(bpl), .fp_level(fpl), .chk(chk),
		.inv(inv), .n_bp(n_bp), .dc_errs(dc_errs), .dc_chks(dc_chks));

	// Main clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// RC pin, phase unrelated to clk
	initial begin
		rc = 1'b0;
		#7;
		forever #62.5 rc = ~rc;
	end
	always @(posedge clk) xdiv <= xdiv + 2'h1;

	task automatic cmp(input logic [95:0] got, input logic [95:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wait_mark();
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (fmark !== 1'b1 && k < 20000);
		cmp(fmark, 1'b1);
	endtask

	// Expected levels of one active half
	task automatic expect_half(input int ph, input int pol, input logic blk);
		for (int b = 0; b < 8; b++)
			eb[b] = 3'(b >= n_bp ? 0 : b == ph ? pol * top : pol ? 1 : top - 1);
		for (int f = 0; f < 32; f++)
			ef[f] = 3'(mem[ph][f] && !(blk && (ball || (f == 0 && ph < ng))) ? (1 - pol) * top :
				bias == 3 ? 2 : bias == 2 ? 1 + pol : bias == 1 ? 1 : pol * top);
	endtask

	// Sample each half at its middle, then time the frame
	task automatic check_frame(input logic first);
		int k, nh;
		logic blk, fp;
		nh = (n_bp + dead) * 2;
		blk = 1'b0;
		fp = 1'b0;
		k = 0;
		do begin
			@(posedge clk);
			k++;
			if (k == 1)
				clr <= 1'b0;
			if (k == 3) begin
				cmp(done, 1'b0);
				cmp(run, 1'b1);
				wr <= '{1'b1, 3'($random(seed)), 32'($random(seed))};
			end
			if (k == 4)
				wr.en <= 1'b0;
			if (k % hl == hl / 2 && k / hl < nh) begin
				if (k / hl == 0) begin
					fp = inv && bpl[0] === 3'(top);
					blk = ng + int'(ball) > 0 && fpl[0] !== 3'((1 - int'(fp)) * top);
					blanked += int'(blk);
					if (inv && !first)
						cmp(fp, !pf);
					pf = fp;
				end
				if (k / hl >= n_bp * 2) begin
					eb = '0;
					ef = '0;
				end else begin
					expect_half(k / hl / 2, inv ? int'(fp) : k / hl % 2, blk);
				end
				cmp(bpl, eb);
				cmp(fpl, ef);
			end
		end while (fmark !== 1'b1 && k < 20000);
		if (sel)
			cmp(k > 96 && k < 104, 1'b1);
		else
			cmp(k, nh * hl);
	endtask

	task automatic run_cfg(input int d, bs, iv, dd, pl, bm, br, sl);
		for (int r = 0; r < 8; r++) begin
			mem[r] = 32'($random(seed)) | 32'h0000_0001;
			wr <= '{1'b1, 3'(r), mem[r]};
			@(posedge clk);
		end
		wr.en <= 1'b0;
		upd_req <= 1'b1;
		@(posedge clk);
		upd_req <= 1'b0;
		// Load the setup with the display enabled
		cfg <= '{1'b1, sl[0], 3'(d), 2'(bs), iv[0], 3'(dd), 16'(pl), 3'(bm), 2'(br)};
		n_bp = d == 4 ? 8 : d + 1;
		top = bs + 1;
		bias = bs;
		dead = dd;
		sel = sl;
		inv = iv[0];
		hl = sl ? 25 : (pl + 1) * 64;
		ng = bm == 5 ? 8 : bm < 5 ? bm : 0;
		ball = bm == 6;
		wait_mark();
		wait_mark();
		cmp(done, 1'b1);
		clr <= 1'b1;
		chk <= !iv[0];
		check_frame(1'b1);
		chk <= 1'b1;
		check_frame(1'b0);
		// A pair check needs one frame ending on each polarity
		if (iv[0])
			check_frame(1'b0);
		chk <= 1'b0;
	endtask

	task automatic final_report();
		num_errors += dc_errs;
		check_count += dc_chks;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		srst = 1'b1;
		xdiv = 2'h0;
		upd_req = 1'b0;
		clr = 1'b0;
		chk = 1'b0;
		inv = 1'b0;
		cfg = '0;
		wr = '0;
		seed = 32'h6301;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		cmp({run, done, fmark, bpl}, '0);
		for (int i = 0; i < 8; i++)
			run_cfg(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3], tbl[i][4], tbl[i][5], tbl[i][6], tbl[i][7]);
		cfg.en <= 1'b0;
		wait_mark();
		repeat (2) @(posedge clk);
		cmp({run, bpl}, '0);
		cmp(fpl, '0);
		cmp(blanked > 0, 1'b1);
		final_report();
	end

	// Watchdog
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		final_report();
	end
endmodule
